// [core/iar_ctrl.sv]
// Purpose: insulation alarm sequencing with relays, lamps and AXI4-Lite registers
// Assumes: resistance sample written by software, ack button synchronous and clean
// Notes:   relay outputs are active high "switched"; polarity is handled outside
// Function
// R1: resistance below preventive threshold switches preventive relay and lights its lamp
// R2: fault waits configured alarm delay, then alarm state, alarm relay and LED
// R3: acknowledge disabled: button press leaves both relays switched
// R4: fault corrected turns LED off and returns to normal monitoring
// R5: corrected-fault enabled: alarm relay pulses 3 s when insulation recovers
// R6: corrected-fault setting is on/off, off after reset
// R7: corrected-fault pulse only acts while acknowledge is enabled
// R8: acknowledge enabled: button in alarm releases both relays
// R9: acknowledge enable setting is on/off, on after reset
// R10: delay and pulse timed from prescaled tick; counters clear on reset
`timescale 1ns/1ns
module iar_ctrl (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // read address and data
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // front panel, relays and interrupt
  input  wire logic        ack_button,
  output logic             prev_relay,
  output logic             prev_lamp,
  output logic             alarm_relay,
  output logic             alarm_led,
  output logic             irq
);
  // register file state
  logic [1:0]  ctrl_reg, ctrl_next;
  logic [31:0] prev_thr_reg, prev_thr_next, alm_thr_reg, alm_thr_next;
  logic [31:0] delay_reg, delay_next, res_reg, res_next;
  logic [3:0]  ist_reg, ist_next, imask_reg, imask_next;
  logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [7:0]  awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  logic        irq_reg, irq_next;
  logic        awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, arrdy_reg, arrdy_next;
  // sequencer state
  iar_pkg::iar_state_e st_reg, st_next;
  logic [31:0] div_reg, div_next, cnt_reg, cnt_next;
  logic        tick_reg, tick_next;
  logic        pr_reg, pr_next, ar_reg, ar_next, led_reg, led_next;
  logic        btn_reg, btn_next;
  logic [3:0]  ev;
  logic        do_wr, rd_take, ack_en, corr_en, below_prev, below_alm, press;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a == iar_pkg::OFS_CTRL || a == iar_pkg::OFS_PREV_THR ||
           a == iar_pkg::OFS_ALM_THR || a == iar_pkg::OFS_DELAY ||
           a == iar_pkg::OFS_RES || a == iar_pkg::OFS_STATUS ||
           a == iar_pkg::OFS_IRQ_STAT || a == iar_pkg::OFS_IRQ_MASK;
  endfunction

  assign ack_en     = ctrl_reg[iar_pkg::CTRL_ACK_BIT];
  assign corr_en    = ctrl_reg[iar_pkg::CTRL_CORR_BIT];
  assign below_prev = res_reg < prev_thr_reg;
  assign below_alm  = res_reg < alm_thr_reg;
  assign press      = ack_button && !btn_reg;
  assign do_wr      = aw_reg && w_reg && !bv_reg;
  assign rd_take    = s_axi_arvalid && !rv_reg;

  // bus slave and registers
  always_comb begin
    aw_next = aw_reg; w_next = w_reg; bv_next = bv_reg; rv_next = rv_reg;
    awa_next = awa_reg; wd_next = wd_reg; ws_next = ws_reg;
    br_next = br_reg; rr_next = rr_reg; rd_next = rd_reg;
    ctrl_next = ctrl_reg; prev_thr_next = prev_thr_reg; alm_thr_next = alm_thr_reg;
    delay_next = delay_reg; res_next = res_reg; imask_next = imask_reg;
    ist_next = ist_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bv_next = 1'b1;
      br_next = known(awa_reg) ? iar_pkg::RESP_OKAY : iar_pkg::RESP_SLVERR;
      unique case (awa_reg)
        iar_pkg::OFS_CTRL:     ctrl_next = 2'(merge({30'h0, ctrl_reg},
                                                    wd_reg, ws_reg)); // see R6 see R9
        iar_pkg::OFS_PREV_THR: prev_thr_next = merge(prev_thr_reg, wd_reg, ws_reg);
        iar_pkg::OFS_ALM_THR:  alm_thr_next = merge(alm_thr_reg, wd_reg, ws_reg);
        iar_pkg::OFS_DELAY:    delay_next = merge(delay_reg, wd_reg, ws_reg);
        iar_pkg::OFS_RES:      res_next = merge(res_reg, wd_reg, ws_reg);
        iar_pkg::OFS_IRQ_MASK: imask_next = 4'(merge({28'h0, imask_reg}, wd_reg, ws_reg));
        default: ;
      endcase
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    if (rd_take) begin
      rv_next = 1'b1;
      rr_next = known(s_axi_araddr) ? iar_pkg::RESP_OKAY : iar_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        iar_pkg::OFS_CTRL:     rd_next = {30'h0, ctrl_reg};
        iar_pkg::OFS_PREV_THR: rd_next = prev_thr_reg;
        iar_pkg::OFS_ALM_THR:  rd_next = alm_thr_reg;
        iar_pkg::OFS_DELAY:    rd_next = delay_reg;
        iar_pkg::OFS_RES:      rd_next = res_reg;
        iar_pkg::OFS_STATUS:   rd_next = {25'h0, st_reg, 1'b0, led_reg, ar_reg, pr_reg};
        iar_pkg::OFS_IRQ_STAT: rd_next = {28'h0, ist_reg};
        iar_pkg::OFS_IRQ_MASK: rd_next = {28'h0, imask_reg};
        default:               rd_next = 32'h0;
      endcase
      if (s_axi_araddr == iar_pkg::OFS_IRQ_STAT) begin
        ist_next = 4'h0;
      end
    end
    ist_next = ist_next | ev;
    irq_next = |(ist_next & imask_reg);
    // readies are kept in flops of their own so every output is registered
    awrdy_next = !aw_next;
    wrdy_next = !w_next;
    arrdy_next = !rv_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; bv_reg <= 1'b0; rv_reg <= 1'b0;
      awa_reg <= 8'h00; wd_reg <= 32'h0; ws_reg <= 4'h0;
      br_reg <= 2'h0; rr_reg <= 2'h0; rd_reg <= 32'h0;
      ctrl_reg <= iar_pkg::CTRL_RESET; // see R6 see R9
      prev_thr_reg <= iar_pkg::PREV_THR_RST; alm_thr_reg <= iar_pkg::ALM_THR_RST;
      delay_reg <= iar_pkg::DELAY_RST; res_reg <= iar_pkg::RES_RST;
      imask_reg <= 4'h0; ist_reg <= 4'h0; irq_reg <= 1'b0;
      awrdy_reg <= 1'b1;
      wrdy_reg <= 1'b1;
      arrdy_reg <= 1'b1;
    end else begin
      aw_reg <= aw_next; w_reg <= w_next; bv_reg <= bv_next; rv_reg <= rv_next;
      awa_reg <= awa_next; wd_reg <= wd_next; ws_reg <= ws_next;
      br_reg <= br_next; rr_reg <= rr_next; rd_reg <= rd_next;
      ctrl_reg <= ctrl_next; prev_thr_reg <= prev_thr_next; alm_thr_reg <= alm_thr_next;
      delay_reg <= delay_next; res_reg <= res_next;
      imask_reg <= imask_next; ist_reg <= ist_next; irq_reg <= irq_next;
      awrdy_reg <= awrdy_next;
      wrdy_reg <= wrdy_next;
      arrdy_reg <= arrdy_next;
    end
  end

  // alarm sequencer
  always_comb begin
    st_next = st_reg; cnt_next = cnt_reg; ev = 4'h0;
    btn_next = ack_button;
    tick_next = (div_reg == iar_pkg::TICK_DIV - 1);
    div_next = tick_next ? 32'h0 : div_reg + 32'h1; // see R10
    pr_next = below_prev; // see R1
    ar_next = ar_reg; led_next = led_reg;
    ev[iar_pkg::EV_PREV] = below_prev && !pr_reg;
    unique case (st_reg)
      iar_pkg::ST_NORMAL: begin
        ar_next = 1'b0; led_next = 1'b0;
        if (below_alm) begin
          st_next = iar_pkg::ST_DELAY;
          cnt_next = 32'h0;
        end
      end
      iar_pkg::ST_DELAY: begin
        if (!below_alm) begin
          st_next = iar_pkg::ST_NORMAL;
        end else if (cnt_reg >= delay_reg) begin // see R2
          st_next = iar_pkg::ST_ALARM;
          ar_next = 1'b1; led_next = 1'b1;
          ev[iar_pkg::EV_ALARM] = 1'b1;
        end else if (tick_reg) begin
          cnt_next = cnt_reg + 32'h1; // see R10
        end
      end
      iar_pkg::ST_ALARM, iar_pkg::ST_ACKED: begin
        if (st_reg == iar_pkg::ST_ACKED) begin
          pr_next = 1'b0; // see R8
        end
        if (!below_alm) begin
          led_next = 1'b0; // see R4
          ev[iar_pkg::EV_CLEAR] = 1'b1;
          cnt_next = 32'h0;
          if (ack_en && corr_en) begin // see R5 see R7
            st_next = iar_pkg::ST_REACT;
            ar_next = 1'b1;
          end else begin
            st_next = iar_pkg::ST_NORMAL;
            ar_next = 1'b0;
          end
        end else if (press && ack_en && st_reg == iar_pkg::ST_ALARM) begin // see R8 see R3
          st_next = iar_pkg::ST_ACKED;
          ar_next = 1'b0;
          pr_next = 1'b0;
          ev[iar_pkg::EV_ACK] = 1'b1;
        end
      end
      iar_pkg::ST_REACT: begin
        if (cnt_reg >= iar_pkg::REACT_TICKS) begin // see R5
          st_next = iar_pkg::ST_NORMAL;
          ar_next = 1'b0;
        end else if (tick_reg) begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      default: begin
        st_next = iar_pkg::ST_NORMAL;
        ar_next = 1'b0; led_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= iar_pkg::ST_NORMAL;
      div_reg <= 32'h0; cnt_reg <= 32'h0; tick_reg <= 1'b0; // see R10
      pr_reg <= 1'b0; ar_reg <= 1'b0; led_reg <= 1'b0; btn_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next; cnt_reg <= cnt_next; tick_reg <= tick_next;
      pr_reg <= pr_next; ar_reg <= ar_next; led_reg <= led_next; btn_reg <= btn_next;
    end
  end

  assign s_axi_awready = awrdy_reg;
  assign s_axi_wready  = wrdy_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arrdy_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign prev_relay    = pr_reg;
  assign prev_lamp     = pr_reg;
  assign alarm_relay   = ar_reg;
  assign alarm_led     = led_reg;
  assign irq           = irq_reg;

  // assertions
  a_prev_follows: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
    st_reg == iar_pkg::ST_NORMAL && below_prev |=> prev_relay)
    else $error("preventive relay did not follow threshold");
  a_alarm_entry: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
    $rose(alarm_led) |-> $past(st_reg) == iar_pkg::ST_DELAY && alarm_relay)
    else $error("alarm led rose outside delay expiry");
  a_noack_holds: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
    st_reg == iar_pkg::ST_ALARM && !ack_en && below_alm |=> alarm_relay)
    else $error("alarm relay released without acknowledge enable");
  a_clear_led: assert property (@(posedge aclk) disable iff (!aresetn) // see R4
    (st_reg == iar_pkg::ST_ALARM || st_reg == iar_pkg::ST_ACKED) && !below_alm
    |=> !alarm_led)
    else $error("alarm led stayed on after fault cleared");
  a_react_on: assert property (@(posedge aclk) disable iff (!aresetn) // see R5
    st_reg == iar_pkg::ST_REACT |-> alarm_relay)
    else $error("relay not driven during reactivation");
  a_react_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
    st_next == iar_pkg::ST_REACT && st_reg != iar_pkg::ST_REACT |-> ack_en && corr_en)
    else $error("reactivation without both settings");
  a_ack_release: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
    st_reg == iar_pkg::ST_ALARM && ack_en && press && below_alm
    |=> !alarm_relay && !prev_relay)
    else $error("acknowledge did not release relays");
  a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
    tick_reg |=> !tick_reg)
    else $error("prescaler tick longer than one cycle");
  a_cnt_clear: assert property (@(posedge aclk) // see R10
    !aresetn |=> cnt_reg == 32'h0 && div_reg == 32'h0)
    else $error("counters not cleared by reset");
  a_acked_prev: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
    st_reg == iar_pkg::ST_ACKED |-> !prev_relay)
    else $error("preventive relay switched while acknowledged");
  c_fault_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    st_reg == iar_pkg::ST_ALARM && !below_alm);
  c_alarm: cover property (@(posedge aclk) disable iff (!aresetn) $rose(alarm_led));
  c_acked: cover property (@(posedge aclk) disable iff (!aresetn)
    st_reg == iar_pkg::ST_ACKED);
  c_react: cover property (@(posedge aclk) disable iff (!aresetn)
    st_reg == iar_pkg::ST_REACT);
endmodule

// [include/iar_pkg.sv]
// Purpose: constants shared by the insulation alarm relay control block
// Assumes: 250 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   resistance values are unsigned ohm counts
package iar_pkg;
  localparam int unsigned CLK_HZ        = 250000000;
  localparam int unsigned TICK_HZ       = 1000;
  localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
  localparam int unsigned REACT_TIME_S  = 3;
  localparam logic [31:0] REACT_TICKS   = 32'(REACT_TIME_S * TICK_HZ);
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_PREV_THR  = 8'h04;
  localparam logic [7:0]  OFS_ALM_THR   = 8'h08;
  localparam logic [7:0]  OFS_DELAY     = 8'h0c;
  localparam logic [7:0]  OFS_RES       = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h1c;
  localparam int unsigned CTRL_ACK_BIT  = 0;
  localparam int unsigned CTRL_CORR_BIT = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;
  localparam logic [31:0] PREV_THR_RST  = 32'h0000c350;
  localparam logic [31:0] ALM_THR_RST   = 32'h00002710;
  localparam logic [31:0] DELAY_RST     = 32'h00000001;
  localparam logic [31:0] RES_RST       = 32'hffffffff;
  localparam int unsigned EV_W          = 4;
  localparam int unsigned EV_PREV       = 0;
  localparam int unsigned EV_ALARM      = 1;
  localparam int unsigned EV_ACK        = 2;
  localparam int unsigned EV_CLEAR      = 3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_DELAY  = 3'h1,
    ST_ALARM  = 3'h2,
    ST_ACKED  = 3'h3,
    ST_REACT  = 3'h4
  } iar_state_e;
endpackage

// [tb/iar_panel.sv]
// Purpose: front panel model with acknowledge push button and relay watch
// Assumes: button is clean and synchronous to aclk
// Notes:   counts switch-on events of the insulation alarm relay
`timescale 1ns/1ns
module iar_panel (
  // clock
  input  wire logic aclk,
  // relay watched by the far side
  input  wire logic alarm_relay,
  // push button
  output logic      ack_button
);
  int   alarm_rises = 0;
  logic relay_q     = 1'b0;
  initial ack_button = 1'b0;
  always @(posedge aclk) begin
    relay_q <= alarm_relay;
    if (alarm_relay && !relay_q) alarm_rises <= alarm_rises + 1;
  end
  // a press lasts three cycles, rising just after an edge
  task automatic press;
    @(posedge aclk);
    ack_button <= 1'b1;
    repeat (3) @(posedge aclk);
    ack_button <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
endmodule

// [tb/tb_top.sv]
// Purpose: register driven test of the alarm sequencing block
// Assumes: alarm delay set to zero ticks so runs stay short
// Notes:   the 3 s pulse is only checked to start and to hold
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, ack_button, irq;
  logic        prev_relay, prev_lamp, alarm_relay, alarm_led;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs_q;
  int          mismatches = 0;
  int          total_checks = 0;
  int          rises;
  iar_ctrl iar_ctrl_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ack_button,
    .prev_relay, .prev_lamp, .alarm_relay, .alarm_led, .irq);
  iar_panel iar_panel_i (.aclk, .alarm_relay, .ack_button);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic stop_test;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    cyc(20);
    aresetn <= 1'b1;
  endtask
  // readies are looked at mid-cycle, so the handshake edge is the next one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, done;
    aw_t = 1'b0;
    w_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      done = (s_axi_bvalid === 1'b1);
      aw_t = (s_axi_awvalid === 1'b1) && (s_axi_awready === 1'b1);
      w_t = (s_axi_wvalid === 1'b1) && (s_axi_wready === 1'b1);
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!done);
    `CHK(s_axi_bresp, iar_pkg::RESP_OKAY)
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_t, done;
    ar_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      done = (s_axi_rvalid === 1'b1);
      rd_q = s_axi_rdata;
      rs_q = s_axi_rresp;
      ar_t = (s_axi_arvalid === 1'b1) && (s_axi_arready === 1'b1);
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!done);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_q, e)
    `CHK(rs_q, iar_pkg::RESP_OKAY)
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    do_reset();
    rd_chk(iar_pkg::OFS_CTRL, 32'h00000001);
    rd_chk(iar_pkg::OFS_PREV_THR, iar_pkg::PREV_THR_RST);
    rd(8'h40);
    `CHK(rs_q, iar_pkg::RESP_SLVERR)
    `CHK(rd_q, 32'h00000000)
    for (int i = 0; i < 4; i++) begin
      wr(iar_pkg::OFS_CTRL, 32'(i));
      rd_chk(iar_pkg::OFS_CTRL, 32'(i));
    end
    wr(iar_pkg::OFS_CTRL, 32'h00000001);
    wr(iar_pkg::OFS_DELAY, 32'h00000000);
    wr(iar_pkg::OFS_IRQ_MASK, 32'h0000000f);
    wr(iar_pkg::OFS_RES, 32'h00004e20);
    cyc(4);
    `CHK({prev_relay, prev_lamp, alarm_relay, irq}, 4'hd)
    rd_chk(iar_pkg::OFS_IRQ_STAT, 32'h00000001);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(iar_pkg::OFS_RES, 32'h000001f4);
    cyc(8);
    `CHK({alarm_relay, alarm_led}, 2'h3)
    rd_chk(iar_pkg::OFS_STATUS, 32'h00000027);
    iar_panel_i.press();
    `CHK({prev_relay, alarm_relay, alarm_led}, 3'h1)
    wr(iar_pkg::OFS_RES, 32'h00086470);
    cyc(4);
    `CHK({alarm_relay, alarm_led}, 2'h0)
    rd_chk(iar_pkg::OFS_STATUS, 32'h00000000);
    // acknowledge off, corrected-fault on: button and pulse both ignored
    wr(iar_pkg::OFS_CTRL, 32'h00000002);
    wr(iar_pkg::OFS_RES, 32'h000001f4);
    cyc(8);
    iar_panel_i.press();
    `CHK({prev_relay, alarm_relay, alarm_led}, 3'h7)
    wr(iar_pkg::OFS_RES, 32'h00086470);
    cyc(4);
    `CHK({alarm_relay, alarm_led}, 2'h0)
    wr(iar_pkg::OFS_CTRL, 32'h00000003);
    wr(iar_pkg::OFS_RES, 32'h000001f4);
    cyc(8);
    iar_panel_i.press();
    rises = iar_panel_i.alarm_rises;
    wr(iar_pkg::OFS_RES, 32'h00086470);
    cyc(4);
    `CHK({alarm_relay, alarm_led}, 2'h2)
    rd_chk(iar_pkg::OFS_STATUS, 32'h00000042);
    cyc(1000);
    `CHK(alarm_relay, 1'b1)
    `CHK(iar_panel_i.alarm_rises, rises + 1)
    do_reset();
    cyc(2);
    `CHK({alarm_relay, prev_relay, irq}, 3'h0)
    rd_chk(iar_pkg::OFS_CTRL, 32'h00000001);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
endmodule
